// ### rpc_pkg.sv
// How it works
// - Smaller nonzero four-bit rank wins during automatic selection.
// - Rank zero removes the input; ranks one to fifteen are used.
// - Even input sits in the upper nibble, odd input in the lower.
// - Bit 4 of path select steers accesses: 0 primary, 1 auxiliary.
// - Inputs 5/6 reset to 0x76 and 7/8 to 0x98 in both sets.
// - Inputs 9/10 reset to 0xba in both sets.
// - Inputs 11/12 reset to 0xdc primary, zero auxiliary.
// - Inputs 13/14 reset to 0xfe primary, zero auxiliary.
// - Setup bits 5:4 pick one of four leak profiles per input.
// - Inputs 1 and 2 setup: other bits zero, 8 kHz only.
// - Inputs 1 and 2 setup registers reset to zero, profile 0.
package rpc_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int NUM_PAIRS = 5;
  localparam int NUM_INPUTS = 10;
  localparam int RANK_W = 4;
  localparam int FIRST_INPUT = 5;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_INPUT5_6_RANK = 7'h1a;
  localparam logic [ADDR_W-1:0] ADDR_INPUT7_8_RANK = 7'h1b;
  localparam logic [ADDR_W-1:0] ADDR_INPUT9_10_RANK = 7'h1c;
  localparam logic [ADDR_W-1:0] ADDR_INPUT11_12_RANK = 7'h1d;
  localparam logic [ADDR_W-1:0] ADDR_INPUT13_14_RANK = 7'h1e;
  localparam logic [ADDR_W-1:0] ADDR_INPUT1_SETUP = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_INPUT2_SETUP = 7'h21;
  localparam logic [ADDR_W-1:0] ADDR_PATH_SELECT = 7'h4b;

  // Field positions
  localparam int PATH_SEL_BIT = 4;
  localparam int PROFILE_LSB = 4;
  localparam int PROFILE_W = 2;
  localparam int HI_NIB_LSB = 4;

  // Reset values, index 0 is the pair for inputs 5/6
  localparam logic [NUM_PAIRS-1:0][DATA_W-1:0] PRIM_RESET = {8'hfe, 8'hdc, 8'hba, 8'h98, 8'h76};
  localparam logic [NUM_PAIRS-1:0][DATA_W-1:0] AUX_RESET = {8'h00, 8'h00, 8'hba, 8'h98, 8'h76};
  localparam logic [DATA_W-1:0] SETUP_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PATH_SEL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SETUP_MASK = 8'h30;
  localparam logic [DATA_W-1:0] PATH_SEL_MASK = 8'h10;

  // Strap dependent rank of input 11
  localparam int STRAP_PAIR = 3;
  localparam logic [RANK_W-1:0] RANK_MASTER = 4'hc;
  localparam logic [RANK_W-1:0] RANK_SLAVE = 4'h1;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef struct packed {
    logic [NUM_INPUTS-1:0][RANK_W-1:0] rank;
    logic [NUM_INPUTS-1:0] avail;
  } rpc_rank_set_t;

  typedef struct packed {
    logic [PROFILE_W-1:0] input2_leak_profile;
    logic [PROFILE_W-1:0] input1_leak_profile;
  } rpc_monitor_t;
endpackage

// ### rpc_regs.sv
`timescale 1ns/1ps
module rpc_regs
  import rpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata,
  input wire logic master_slave_strap,
  output logic path_view_select,
  output rpc_rank_set_t primary_timing_path,
  output rpc_rank_set_t auxiliary_timing_path,
  output rpc_monitor_t monitor_setup
);
  logic [NUM_PAIRS-1:0][DATA_W-1:0] prim_r;
  logic [NUM_PAIRS-1:0][DATA_W-1:0] aux_r;
  logic [DATA_W-1:0] setup1_r;
  logic [DATA_W-1:0] setup2_r;
  logic [DATA_W-1:0] path_r;
  logic [DATA_W-1:0] rdata_r;
  logic strap_meta_r;
  logic strap_sync_r;
  logic [1:0] settle_r;
  logic strap_done_r;

  // Address decode
  wire logic [ADDR_W-1:0] pair_off = addr - ADDR_INPUT5_6_RANK;
  wire logic pair_hit = (addr >= ADDR_INPUT5_6_RANK) && (addr <= ADDR_INPUT13_14_RANK);
  wire logic [2:0] pair_idx = pair_off[2:0];
  wire logic aux_view = path_r[PATH_SEL_BIT];
  wire logic wr_prim = wr && pair_hit && !aux_view;
  wire logic wr_aux = wr && pair_hit && aux_view;
  wire logic wr_setup1 = wr && (addr == ADDR_INPUT1_SETUP);
  wire logic wr_setup2 = wr && (addr == ADDR_INPUT2_SETUP);
  wire logic wr_path = wr && (addr == ADDR_PATH_SELECT);

  // Strap load fires once after it has settled; a primary write to inputs 11/12 that cycle wins
  wire logic strap_load = !strap_done_r && (settle_r == STRAP_SETTLE);
  wire logic strap_wr_clash = wr_prim && (pair_idx == 3'(STRAP_PAIR));
  wire logic [RANK_W-1:0] strap_rank = strap_sync_r ? RANK_MASTER : RANK_SLAVE;

  // Read selection; unmapped offsets read zero
  wire logic [DATA_W-1:0] pair_rd = aux_view ? aux_r[pair_idx] : prim_r[pair_idx];
  wire logic [DATA_W-1:0] rd_mux =
    pair_hit ? pair_rd :
    (addr == ADDR_INPUT1_SETUP) ? setup1_r :
    (addr == ADDR_INPUT2_SETUP) ? setup2_r :
    (addr == ADDR_PATH_SELECT) ? path_r : 8'h00;

  // Strap synchroniser; the pin is asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_meta_r <= 1'b0;
      strap_sync_r <= 1'b0;
    end else begin
      strap_meta_r <= master_slave_strap;
      strap_sync_r <= strap_meta_r;
    end
  end

  // Settle counter so the synchroniser holds the true level before sampling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_r <= 2'h0;
      strap_done_r <= 1'b0;
    end else begin
      if (settle_r != STRAP_SETTLE) begin
        settle_r <= settle_r + 2'h1;
      end
      if (strap_load) begin
        strap_done_r <= 1'b1;
      end
    end
  end

  // Primary rank set; a write to another pair must not swallow the one-shot strap load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prim_r <= PRIM_RESET;
    end else begin
      if (wr_prim) begin
        prim_r[pair_idx] <= wdata;
      end
      if (strap_load && !strap_wr_clash) begin
        prim_r[STRAP_PAIR][RANK_W-1:0] <= strap_rank;
      end
    end
  end

  // Auxiliary rank set, independent storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_r <= AUX_RESET;
    end else if (wr_aux) begin
      aux_r[pair_idx] <= wdata;
    end
  end

  // Setup and path select; unused bits never stored, so 8 kHz is fixed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setup1_r <= SETUP_RESET;
      setup2_r <= SETUP_RESET;
      path_r <= PATH_SEL_RESET;
    end else begin
      if (wr_setup1) begin
        setup1_r <= wdata & SETUP_MASK;
      end
      if (wr_setup2) begin
        setup2_r <= wdata & SETUP_MASK;
      end
      if (wr_path) begin
        path_r <= wdata & PATH_SEL_MASK;
      end
    end
  end

  // Registered read data, updated on a read strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (rd) begin
      rdata_r <= rd_mux;
    end
  end

  // Rank outputs for the selection engine; zero rank means unavailable
  always_comb begin
    for (int i = 0; i < NUM_INPUTS; i++) begin
      primary_timing_path.rank[i] = prim_r[i/2][(i%2)*HI_NIB_LSB +: RANK_W];
      auxiliary_timing_path.rank[i] = aux_r[i/2][(i%2)*HI_NIB_LSB +: RANK_W];
      primary_timing_path.avail[i] = |prim_r[i/2][(i%2)*HI_NIB_LSB +: RANK_W];
      auxiliary_timing_path.avail[i] = |aux_r[i/2][(i%2)*HI_NIB_LSB +: RANK_W];
    end
  end

  assign monitor_setup.input1_leak_profile = setup1_r[PROFILE_LSB +: PROFILE_W];
  assign monitor_setup.input2_leak_profile = setup2_r[PROFILE_LSB +: PROFILE_W];
  assign path_view_select = aux_view;
  assign rdata = rdata_r;
endmodule

// ### rpc_regs_properties.sv
`timescale 1ns/1ps
module rpc_chk
  import rpc_pkg::*;
(
  input wire logic clk, rst, wr, rd, master_slave_strap, path_view_select,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata, rdata,
  input wire rpc_rank_set_t primary_timing_path, auxiliary_timing_path,
  input wire rpc_monitor_t monitor_setup
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Writes land one edge later
  a_path_bit: assert property (wr && addr == ADDR_PATH_SELECT |=> path_view_select == $past(wdata[4]))
    else $error("path bit");
  a_prim_rank: assert property (wr && addr == ADDR_INPUT7_8_RANK && !path_view_select |=>
    primary_timing_path.rank[3] == $past(wdata[7:4])) else $error("prim rank");
  a_aux_rank: assert property (wr && addr == ADDR_INPUT9_10_RANK && path_view_select |=>
    auxiliary_timing_path.rank[4] == $past(wdata[3:0])) else $error("aux rank");
  a_profile_set: assert property (wr && addr == ADDR_INPUT2_SETUP |=>
    monitor_setup.input2_leak_profile == $past(wdata[5:4])) else $error("profile");
  a_setup_zero: assert property (rd && addr == ADDR_INPUT1_SETUP |=>
    rdata[7:6] == 2'h0 && rdata[3:0] == 4'h0) else $error("setup bits");
  // Strap only touches primary, so aux never moves without a write
  a_aux_hold: assert property (!wr |=> $stable(auxiliary_timing_path)) else $error("aux moved");
  a_aux_reset: assert property ($fell(rst) |-> auxiliary_timing_path.rank[9:6] == 16'h0)
    else $error("aux reset");
  a_read_back: assert property (rd && !wr && addr == ADDR_INPUT5_6_RANK && !path_view_select |=>
    rdata == $past({primary_timing_path.rank[1], primary_timing_path.rank[0]})) else $error("readback");
endmodule
bind rpc_regs rpc_chk chk_u (.*);

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rpc_pkg::*;
;
  logic clk = 0, rst = 1, wr = 0, rd = 0, strap = 1, psel;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  rpc_rank_set_t prim, aux;
  rpc_monitor_t mon;
  int error_cnt = 0, checks_done = 0;
  rpc_regs dut_u (.clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata),
    .master_slave_strap(strap), .path_view_select(psel), .primary_timing_path(prim),
    .auxiliary_timing_path(aux), .monitor_setup(mon));
  // 40 ns clock
  initial forever #20 clk = ~clk;
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // Settle 1 ns after the edge so the design's update is seen
  task automatic wrt(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    #1;
  endtask
  task automatic chk(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 cmp($sformatf("reg %h", a), e, rdata);
  endtask
  // Strap load lands on the 4th edge after release; n edges are waited here
  task automatic boot(input logic s, input int n);
    strap <= s;
    rst <= 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    repeat (n) @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    boot(1'b1, 6);
    for (int i = 0; i < NUM_PAIRS; i++) chk(ADDR_INPUT5_6_RANK + 7'(i), PRIM_RESET[i]);
    chk(ADDR_INPUT1_SETUP, 8'h00);
    chk(ADDR_INPUT2_SETUP, 8'h00);
    $display("test reset_values done");
    wrt(ADDR_PATH_SELECT, 8'hff);
    chk(ADDR_PATH_SELECT, 8'h10);
    cmp("path view", 8'h01, {7'h0, psel});
    for (int i = 0; i < NUM_PAIRS; i++) chk(ADDR_INPUT5_6_RANK + 7'(i), AUX_RESET[i]);
    wrt(ADDR_INPUT11_12_RANK, 8'h3a);
    wrt(ADDR_INPUT9_10_RANK, 8'h05);
    chk(ADDR_INPUT11_12_RANK, 8'h3a);
    cmp("aux avail 11/12", 8'h03, {6'h0, aux.avail[7:6]});
    cmp("aux avail 13/14", 8'h00, {6'h0, aux.avail[9:8]});
    wrt(ADDR_PATH_SELECT, 8'h00);
    cmp("path view", 8'h00, {7'h0, psel});
    chk(ADDR_INPUT11_12_RANK, 8'hdc);
    chk(ADDR_INPUT9_10_RANK, 8'hba);
    wrt(ADDR_INPUT7_8_RANK, 8'h10);
    cmp("avail 7/8", 8'h02, {6'h0, prim.avail[3:2]});
    cmp("rank 8", 8'h01, {4'h0, prim.rank[3]});
    wrt(ADDR_INPUT2_SETUP, 8'hff);
    chk(ADDR_INPUT2_SETUP, 8'h30);
    cmp("profile 2", 8'h03, {6'h0, mon.input2_leak_profile});
    wrt(ADDR_INPUT1_SETUP, 8'hdf);
    chk(ADDR_INPUT1_SETUP, 8'h10);
    cmp("profile 1", 8'h01, {6'h0, mon.input1_leak_profile});
    wrt(7'h7f, 8'h55);
    chk(7'h7f, 8'h00);
    $display("test access done");
    boot(1'b0, 2);
    wrt(ADDR_INPUT5_6_RANK, 8'h21);
    chk(ADDR_INPUT11_12_RANK, 8'hd1);
    chk(ADDR_INPUT5_6_RANK, 8'h21);
    $display("test slave_strap done");
    summarize;
  end
endmodule
